// File: core/sar_pkg.sv
/*
 * constants, codes and state encoding shared by the conversion control block,
 * its result fifo and the stream interface between them.
 * assumes a 125 MHz system clock and a pin-level serial link sampled by it.
 */

package sar_pkg;
	localparam int RESULT_W = 16; // result and array width
	localparam int CFG_W = 14; // configuration word width
	localparam int CLK_PERIOD_NS = 8; // system clock period
	localparam int SAMPLE_PERIOD_NS = 2000; // one sample at 500 kSPS
	// longest time: round down to whole cycles
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CONV_DIV = 4; // system cycles per conversion clock tick
	localparam int FIFO_DEPTH = 8; // result words buffered
	localparam int CFG_INCC_MSB = 12; // high bit of input config field
	localparam int CFG_RB_BIT = 0; // low means readback appended
	localparam logic [13:0] CFG_RESET = 14'h3C00; // unipolar single ended
	localparam logic [15:0] UNI_MAX = 16'hFFFF; // unipolar full scale
	localparam logic [15:0] UNI_MIN = 16'h0000; // unipolar zero
	localparam logic [15:0] BIP_MAX = 16'h7FFF; // bipolar top
	localparam logic [15:0] BIP_MIN = 16'h8000; // bipolar bottom
	localparam logic [15:0] SIGN_FLIP = 16'h8000; // offset binary to twos
	localparam logic [4:0] FRAME_SHORT = 5'h10; // result only
	localparam logic [4:0] FRAME_LONG = 5'h1E; // result plus readback
	localparam logic [4:0] CFG_BITS = 5'h0E; // edges to capture config

	typedef enum logic [2:0] {
		ST_ACQ = 3'b000,
		ST_OPEN = 3'b001,
		ST_HOLD = 3'b010,
		ST_TRIAL = 3'b011,
		ST_DONE = 3'b100
	} conv_state_e;
endpackage : sar_pkg

// File: core/sar_stream_if.sv
/*
 * valid/ready word stream between the converter and its result fifo.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface sar_stream_if #(parameter int WIDTH = 16);
	logic valid; // word offered
	logic ready; // word accepted this cycle when valid
	logic [WIDTH-1:0] data; // word

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sar_stream_if
`default_nettype wire

// File: core/sar_fifo.sv
/*
 * synchronous fifo with registered read data, valid/ready on both sides.
 * assumes one clock, an active low async reset and a freezing clock enable.
 */
`timescale 1ns/100ps
`default_nettype none
module sar_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	sar_stream_if.snk wr,
	sar_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage
	logic [AW-1:0] wptr_q; // next write slot
	logic [AW-1:0] rptr_q; // next read slot
	logic [AW:0] count_q; // words held, including the output register
	logic out_valid_q; // output register holds a word
	logic [WIDTH-1:0] out_q; // registered read data
	logic push;
	logic pop;
	logic load;

	// honest full: the output register counts as a slot
	assign wr.ready = (count_q < (AW+1)'(DEPTH));
	assign push = wr.valid && wr.ready;
	// refill output register when empty or being drained
	assign load = (count_q > (AW+1)'(out_valid_q)) && (!out_valid_q || rd.ready);
	assign pop = out_valid_q && rd.ready;
	assign rd.valid = out_valid_q;
	assign rd.data = out_q;

	// storage write, no reset needed on data
	always_ff @(posedge sys_clk)
	begin
		if (clk_en && push)
		begin
			mem_q[wptr_q] <= wr.data;
		end
	end

	// pointers, occupancy and output register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
			out_valid_q <= 1'b0;
			out_q <= '0;
		end
		else if (clk_en)
		begin
			if (push)
			begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (load)
			begin
				out_q <= mem_q[rptr_q];
				rptr_q <= rptr_q + 1'b1;
				out_valid_q <= 1'b1;
			end
			else if (pop)
			begin
				out_valid_q <= 1'b0;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sar_fifo
`default_nettype wire

// File: core/sar_conversion_control.sv
/*
 * control logic of a 16 bit successive approximation converter: acquisition,
 * switch sequencing, msb first bit search, output coding and saturation, and
 * the serial port that returns results and takes the configuration word.
 * assumes the analog array answers on comp_high one conversion tick after a
 * trial pattern is applied, and that the host drives convert_start, the serial
 * clock and the serial data in from its own, unrelated clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_control #(
	parameter int CONV_DIV = sar_pkg::CONV_DIV,
	parameter int FIFO_DEPTH = sar_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic convert_start,
	input wire logic serial_clk,
	input wire logic serial_cfg_in,
	input wire logic comp_high,
	input wire logic over_range,
	input wire logic under_range,
	output logic serial_result_out,
	output logic sampling_switch_pos,
	output logic sampling_switch_neg,
	output logic arrays_on_inputs,
	output logic [sar_pkg::RESULT_W-1:0] dac_pos_bits,
	output logic [sar_pkg::RESULT_W-1:0] dac_neg_bits,
	output logic conv_power_en,
	output logic busy,
	output logic [sar_pkg::CFG_W-1:0] cfg_word
);
	localparam int DW = $clog2(CONV_DIV) + 1;

	sar_pkg::conv_state_e state_q; // conversion phase
	logic [2:0] cnv_sync_q; // convert start synchroniser plus edge stage
	logic [2:0] sck_sync_q; // serial clock synchroniser plus edge stage
	logic [1:0] din_sync_q; // serial data in synchroniser
	logic cnv_rise;
	logic sck_rise;
	logic sck_fall;
	logic [DW-1:0] div_q; // conversion clock divider
	logic tick; // one conversion clock period elapsed
	logic [3:0] bit_idx_q; // bit under trial
	logic [15:0] sar_q; // bits decided so far
	logic over_q; // input above full scale at hold
	logic under_q; // input below ground at hold
	logic [15:0] code_q; // final coded result
	logic busy_mode_q; // convert start held high through conversion
	logic [29:0] shift_q; // outgoing result and readback
	logic [13:0] cfg_shift_q; // incoming configuration bits
	logic [13:0] cfg_q; // configuration register
	logic [4:0] bit_cnt_q; // serial edges in this frame
	logic frame_q; // a result frame is being read
	logic frame_long_q; // readback appended to the frame under way
	logic sdo_q; // registered serial output
	logic bipolar;
	logic [15:0] trial;
	logic [4:0] frame_len;

	sar_stream_if #(.WIDTH(sar_pkg::RESULT_W)) res_in ();
	sar_stream_if #(.WIDTH(sar_pkg::RESULT_W)) res_out ();

	sar_fifo #(
		.WIDTH(sar_pkg::RESULT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.wr(res_in.snk),
		.rd(res_out.src)
	);

	// pin synchronisers; edge detectors look only at stages two and three
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnv_sync_q <= '0;
			sck_sync_q <= '0;
			din_sync_q <= '0;
		end
		else if (clk_en)
		begin
			cnv_sync_q <= {cnv_sync_q[1:0], convert_start};
			sck_sync_q <= {sck_sync_q[1:0], serial_clk};
			din_sync_q <= {din_sync_q[0], serial_cfg_in};
		end
	end

	assign cnv_rise = cnv_sync_q[1] && !cnv_sync_q[2];
	assign sck_rise = sck_sync_q[1] && !sck_sync_q[2];
	assign sck_fall = !sck_sync_q[1] && sck_sync_q[2];
	// input configs with a high top bit are ground sensed, the rest are mid-reference
	assign bipolar = !cfg_q[sar_pkg::CFG_INCC_MSB];
	assign trial = sar_q | (16'h0001 << bit_idx_q);

	// internal conversion clock, idle while acquiring to save power
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= '0;
		end
		else if (clk_en)
		begin
			if (state_q == sar_pkg::ST_ACQ || tick)
			begin
				div_q <= '0;
			end
			else
			begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	assign tick = (div_q == DW'(CONV_DIV - 1));

	// conversion sequence; a full fifo holds off the next start
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= sar_pkg::ST_ACQ;
			bit_idx_q <= '0;
			sar_q <= '0;
			over_q <= 1'b0;
			under_q <= 1'b0;
		end
		else if (clk_en)
		begin
			unique case (state_q)
				sar_pkg::ST_ACQ:
				begin
					if (cnv_rise && res_in.ready)
					begin
						state_q <= sar_pkg::ST_OPEN;
					end
				end
				sar_pkg::ST_OPEN:
				begin
					if (tick)
					begin
						state_q <= sar_pkg::ST_HOLD;
					end
				end
				sar_pkg::ST_HOLD:
				begin
					if (tick)
					begin
						// held charge is final now, so range flags are taken here
						over_q <= over_range;
						under_q <= under_range;
						sar_q <= '0;
						bit_idx_q <= 4'hF;
						state_q <= sar_pkg::ST_TRIAL;
					end
				end
				sar_pkg::ST_TRIAL:
				begin
					if (tick)
					begin
						// keep the trial bit when the input still outweighs it
						if (comp_high)
						begin
							sar_q <= trial;
						end
						if (bit_idx_q == 4'h0)
						begin
							state_q <= sar_pkg::ST_DONE;
						end
						else
						begin
							bit_idx_q <= bit_idx_q - 1'b1;
						end
					end
				end
				sar_pkg::ST_DONE:
				begin
					if (res_in.ready)
					begin
						state_q <= sar_pkg::ST_ACQ;
					end
				end
				default:
				begin
					state_q <= sar_pkg::ST_ACQ;
				end
			endcase
		end
	end

	// output coding with saturation; flags win over the searched code
	always_comb
	begin
		if (over_q)
		begin
			code_q = bipolar ? sar_pkg::BIP_MAX : sar_pkg::UNI_MAX;
		end
		else if (under_q)
		begin
			code_q = bipolar ? sar_pkg::BIP_MIN : sar_pkg::UNI_MIN;
		end
		else if (bipolar)
		begin
			code_q = sar_q ^ sar_pkg::SIGN_FLIP;
		end
		else
		begin
			code_q = sar_q;
		end
	end

	// the finished code is latched into the fifo as conversion ends
	assign res_in.valid = (state_q == sar_pkg::ST_DONE);
	assign res_in.data = code_q;

	// switch network: closed switches only while acquiring, input-side arrays while acquiring and in the open phase
	assign sampling_switch_pos = (state_q == sar_pkg::ST_ACQ);
	assign sampling_switch_neg = (state_q == sar_pkg::ST_ACQ);
	assign arrays_on_inputs = (state_q == sar_pkg::ST_ACQ) || (state_q == sar_pkg::ST_OPEN);
	// matched arrays driven in opposite sense
	assign dac_pos_bits = (state_q == sar_pkg::ST_TRIAL) ? trial : sar_q;
	assign dac_neg_bits = ~dac_pos_bits;
	assign conv_power_en = (state_q != sar_pkg::ST_ACQ);
	assign busy = (state_q != sar_pkg::ST_ACQ);
	assign cfg_word = cfg_q;

	// busy on the serial line only while convert start stays high
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_mode_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (state_q == sar_pkg::ST_ACQ)
			begin
				busy_mode_q <= cnv_rise;
			end
			else if (!cnv_sync_q[2])
			begin
				busy_mode_q <= 1'b0;
			end
		end
	end

	// length is fixed when the frame opens: a config written inside it
	// takes effect from the next frame, so a frame never changes length midway
	assign frame_len = frame_long_q ? sar_pkg::FRAME_LONG : sar_pkg::FRAME_SHORT;
	// a new word is taken only between frames, so a read is never torn
	assign res_out.ready = !frame_q;

	// result frame: load, then shift msb first on falling serial edges
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_q <= '0;
			frame_q <= 1'b0;
			frame_long_q <= 1'b0;
			bit_cnt_q <= '0;
		end
		else if (clk_en)
		begin
			if (res_out.valid && !frame_q)
			begin
				shift_q <= {res_out.data, cfg_q};
				frame_q <= 1'b1;
				frame_long_q <= !cfg_q[sar_pkg::CFG_RB_BIT];
				bit_cnt_q <= '0;
			end
			else if (frame_q)
			begin
				if (sck_fall)
				begin
					shift_q <= {shift_q[28:0], 1'b0};
				end
				if (sck_rise)
				begin
					bit_cnt_q <= bit_cnt_q + 1'b1;
				end
				if (sck_fall && bit_cnt_q >= frame_len)
				begin
					frame_q <= 1'b0;
				end
			end
		end
	end

	// configuration shifted in msb first; committed at the fourteenth edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_shift_q <= '0;
			cfg_q <= sar_pkg::CFG_RESET;
		end
		else if (clk_en)
		begin
			if (sck_rise && frame_q && bit_cnt_q < sar_pkg::CFG_BITS)
			begin
				cfg_shift_q <= {cfg_shift_q[12:0], din_sync_q[1]};
				if (bit_cnt_q == sar_pkg::CFG_BITS - 5'h01)
				begin
					cfg_q <= {cfg_shift_q[12:0], din_sync_q[1]};
				end
			end
		end
	end

	// serial output register: busy flag, then data, else low
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sdo_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (busy_mode_q && state_q != sar_pkg::ST_ACQ)
			begin
				sdo_q <= 1'b1;
			end
			else
			begin
				sdo_q <= frame_q && shift_q[29];
			end
		end
	end

	assign serial_result_out = sdo_q;

	// helper: trial ticks and cycles per conversion
	logic [4:0] trial_ticks_q;
	logic [8:0] conv_cycles_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trial_ticks_q <= '0;
			conv_cycles_q <= '0;
		end
		else if (clk_en)
		begin
			trial_ticks_q <= (state_q != sar_pkg::ST_TRIAL) ? 5'h00 :
				trial_ticks_q + 5'(tick);
			conv_cycles_q <= (state_q == sar_pkg::ST_ACQ) ? 9'h000 : conv_cycles_q + 1'b1;
		end
	end

	AST_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && state_q == sar_pkg::ST_ACQ && cnv_rise && res_in.ready
		|=> state_q == sar_pkg::ST_OPEN)
		else $error("conversion did not start on convert start edge");
	AST_SWITCH_ORDER: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(arrays_on_inputs) |-> $past(!sampling_switch_pos) && !sampling_switch_pos)
		else $error("arrays left inputs before switches opened");
	AST_MSB_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(state_q == sar_pkg::ST_TRIAL) |-> bit_idx_q == 4'hF && sar_q == 16'h0000)
		else $error("search did not start at msb");
	AST_SIXTEEN_BITS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && state_q == sar_pkg::ST_TRIAL && tick && bit_idx_q == 4'h0
		|-> trial_ticks_q == 5'h0F)
		else $error("search did not take sixteen steps");
	AST_SAT_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		res_in.valid && over_q |-> res_in.data == (bipolar ? 16'h7FFF : 16'hFFFF))
		else $error("over range not saturated high");
	AST_SAT_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
		res_in.valid && !over_q && under_q |-> res_in.data == (bipolar ? 16'h8000 : 16'h0000))
		else $error("under range not saturated low");
	AST_TWOS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		res_in.valid && !over_q && !under_q && bipolar |-> res_in.data == {~sar_q[15], sar_q[14:0]})
		else $error("bipolar result not twos complement");
	AST_BINARY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		res_in.valid && !over_q && !under_q && !bipolar |-> res_in.data == sar_q)
		else $error("unipolar result not straight binary");
	AST_THROUGHPUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_cycles_q < 9'(sar_pkg::SAMPLE_CYCLES) && (busy || !conv_power_en))
		else $error("conversion too slow or power left on");
	AST_BUSY_LINE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && busy_mode_q && busy |=> serial_result_out)
		else $error("busy not shown on serial output");
endmodule : sar_conversion_control
`default_nettype wire

// File: dv/sar_host_model.sv
/*
 * host controller model: raises convert start and runs serial frames.
 * assumes the bench clock is only used to pace conversion starts; the
 * serial clock is the host's own, 160 ns, and stands low between frames.
 */
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
	input wire logic sys_clk,
	input wire logic busy,
	input wire logic serial_result_out,
	output logic convert_start,
	output logic serial_clk,
	output logic serial_cfg_in
);
	// pins idle low at time zero
	initial
	begin
		convert_start = 1'b0;
		serial_clk = 1'b0;
		serial_cfg_in = 1'b0;
	end

	// start one conversion, holding the pin high for hold cycles
	task automatic start_conv(input int hold);
		while (busy !== 1'b0) @(posedge sys_clk);
		@(posedge sys_clk);
		#1 convert_start = 1'b1;
		repeat (hold) @(posedge sys_clk);
		#1 convert_start = 1'b0;
	endtask : start_conv

	// one 30 bit frame: result then readback, config shifted in meanwhile
	task automatic read_frame(input logic [13:0] cfg, output logic [29:0] word);
		#200;
		for (int i = 29; i >= 0; i--)
		begin
			// config msb first on the first 14 edges, a toggling line after
			if (i >= 16) serial_cfg_in = cfg[i-16];
			else serial_cfg_in = ~serial_cfg_in;
			#80 word[i] = serial_result_out;
			serial_clk = 1'b1;
			#80 serial_clk = 1'b0;
		end
		// released data line must not look like a held value
		serial_cfg_in = ~serial_cfg_in;
	endtask : read_frame
endmodule : sar_host_model
`default_nettype wire

// File: dv/tb_sar_conversion_control.sv
/*
 * self-checking bench of the conversion control block.
 * assumes the host model beside it and a comparator modelled from a level.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_sar_conversion_control;
	localparam logic [13:0] CFG_UNI = 14'h3C00; // unipolar, readback on
	localparam logic [13:0] CFG_BIP = 14'h2C00; // bipolar, readback on
	localparam logic [13:0] CFG_SHORT = 14'h3C01; // unipolar, readback off
	localparam int CONV_DIV = sar_pkg::CONV_DIV; // cycles per conversion tick
	logic sys_clk;
	logic clk_en; // freezes the block while low
	logic rst_n;
	logic convert_start, serial_clk, serial_cfg_in;
	logic over_range, under_range, comp_high;
	logic [15:0] analog_level; // sampled input as an offset binary level
	logic serial_result_out, sampling_switch_pos, sampling_switch_neg;
	logic arrays_on_inputs, conv_power_en, busy;
	logic [sar_pkg::RESULT_W-1:0] dac_pos_bits, dac_neg_bits;
	logic [sar_pkg::CFG_W-1:0] cfg_word;
	int num_errors, compares;

	// ideal comparator: input at or above the trial pattern
	assign comp_high = (analog_level >= dac_pos_bits);

	sar_conversion_control u_sar_conversion_control (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .convert_start(convert_start),
		.serial_clk(serial_clk), .serial_cfg_in(serial_cfg_in), .comp_high(comp_high),
		.over_range(over_range), .under_range(under_range),
		.serial_result_out(serial_result_out), .sampling_switch_pos(sampling_switch_pos),
		.sampling_switch_neg(sampling_switch_neg), .arrays_on_inputs(arrays_on_inputs),
		.dac_pos_bits(dac_pos_bits), .dac_neg_bits(dac_neg_bits),
		.conv_power_en(conv_power_en), .busy(busy), .cfg_word(cfg_word)
	);

	sar_host_model u_sar_host_model (
		.sys_clk(sys_clk), .busy(busy), .serial_result_out(serial_result_out),
		.convert_start(convert_start), .serial_clk(serial_clk),
		.serial_cfg_in(serial_cfg_in)
	);

	// free running system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// verdict and end of run
	task automatic test_done;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// bounded wait for the end of a conversion
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (5) @(posedge sys_clk);
		while (busy !== 1'b0 && n < 300)
		begin
			@(posedge sys_clk);
			n++;
		end
		check(32'(busy), 32'h0000_0000);
	endtask : wait_idle

	// idle state after reset
	task automatic t_reset;
		check(32'({busy, conv_power_en, sampling_switch_pos, sampling_switch_neg}), 32'h0000_0003);
		check(32'(arrays_on_inputs), 32'h0000_0001);
		check(32'({dac_pos_bits, dac_neg_bits}), 32'h0000_FFFF);
		check(32'(cfg_word), 32'(CFG_UNI));
	endtask : t_reset

	// switch order, first trial, conversion length, return to acquisition
	task automatic t_walk;
		int n;
		logic [29:0] w;
		@(posedge sys_clk);
		#1 analog_level = 16'h1234;
		u_sar_host_model.start_conv(2);
		n = 0;
		while (busy !== 1'b1 && n < 10)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check(32'({sampling_switch_pos, sampling_switch_neg, arrays_on_inputs, conv_power_en}), 32'h0000_0003);
		repeat (CONV_DIV) @(posedge sys_clk);
		#1 check(32'(arrays_on_inputs), 32'h0000_0000);
		repeat (CONV_DIV) @(posedge sys_clk);
		#1 check(32'({dac_pos_bits, dac_neg_bits}), 32'h8000_7FFF);
		n = 2 * CONV_DIV + 1;
		while (busy === 1'b1 && n < 300)
		begin
			@(posedge sys_clk);
			#1;
			if (busy === 1'b1) n++;
		end
		check(32'(n), 32'(CONV_DIV * 18 + 1));
		check(32'({sampling_switch_pos, sampling_switch_neg, arrays_on_inputs, conv_power_en}), 32'h0000_000E);
		check(32'(dac_pos_bits), 32'h0000_1234);
		u_sar_host_model.read_frame(CFG_UNI, w);
		check(32'(w), {2'b00, 16'h1234, CFG_UNI});
	endtask : t_walk

	// one conversion and its frame, written config as given
	task automatic t_code(input logic [13:0] cfg, input logic [15:0] lvl, input logic ovr,
		input logic und, input logic [15:0] exp, input bit chk_rb);
		logic [29:0] w;
		@(posedge sys_clk);
		#1 analog_level = lvl;
		over_range = ovr;
		under_range = und;
		u_sar_host_model.start_conv(2);
		wait_idle();
		u_sar_host_model.read_frame(cfg, w);
		check(32'(w[29:14]), 32'(exp));
		if (chk_rb) check(32'(w[13:0]), 32'(cfg));
		check(32'(cfg_word), 32'(cfg));
	endtask : t_code

	// coding, ideal codes and saturation in both ranges
	task automatic t_codes;
		t_code(CFG_UNI, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b1);
		t_code(CFG_UNI, 16'h8000, 1'b0, 1'b0, 16'h8000, 1'b1);
		t_code(CFG_UNI, 16'hFFFF, 1'b0, 1'b0, 16'hFFFF, 1'b1);
		t_code(CFG_UNI, 16'h1234, 1'b1, 1'b0, 16'hFFFF, 1'b1);
		t_code(CFG_UNI, 16'h1234, 1'b0, 1'b1, 16'h0000, 1'b1);
		// range change lands during this frame, so readback is not judged
		t_code(CFG_BIP, 16'h8000, 1'b0, 1'b0, 16'h8000, 1'b0);
		t_code(CFG_BIP, 16'h8000, 1'b0, 1'b0, 16'h0000, 1'b1);
		t_code(CFG_BIP, 16'h0000, 1'b0, 1'b0, 16'h8000, 1'b1);
		t_code(CFG_BIP, 16'hFFFF, 1'b0, 1'b0, 16'h7FFF, 1'b1);
		t_code(CFG_BIP, 16'h8001, 1'b0, 1'b0, 16'h0001, 1'b1);
		t_code(CFG_BIP, 16'h1234, 1'b1, 1'b0, 16'h7FFF, 1'b1);
		t_code(CFG_BIP, 16'h1234, 1'b0, 1'b1, 16'h8000, 1'b1);
		t_code(CFG_UNI, 16'h7FFF, 1'b0, 1'b0, 16'hFFFF, 1'b0);
	endtask : t_codes

	// start held high through conversion shows busy on the serial line
	task automatic t_busy_line;
		logic [29:0] w;
		@(posedge sys_clk);
		#1 analog_level = 16'hBEEF;
		fork
			u_sar_host_model.start_conv(100);
			begin
				repeat (30) @(posedge sys_clk);
				#1 check(32'(serial_result_out), 32'h0000_0001);
			end
		join
		wait_idle();
		u_sar_host_model.read_frame(CFG_UNI, w);
		check(32'(w[29:14]), 32'h0000_BEEF);
	endtask : t_busy_line

	// read during the next conversion returns the older result
	task automatic t_overlap;
		logic [29:0] w;
		@(posedge sys_clk);
		#1 analog_level = 16'hAAAA;
		u_sar_host_model.start_conv(2);
		wait_idle();
		@(posedge sys_clk);
		#1 analog_level = 16'h5555;
		fork
			u_sar_host_model.start_conv(2);
			u_sar_host_model.read_frame(CFG_UNI, w);
		join
		check(32'(w[29:14]), 32'h0000_AAAA);
		u_sar_host_model.read_frame(CFG_UNI, w);
		check(32'(w[29:14]), 32'h0000_5555);
	endtask : t_overlap

	// readback off: a 16 bit frame, line low for the rest of the clocks
	task automatic t_short;
		logic [29:0] w;
		t_code(CFG_SHORT, 16'h4321, 1'b0, 1'b0, 16'h4321, 1'b0);
		@(posedge sys_clk);
		#1 analog_level = 16'h0F0F;
		u_sar_host_model.start_conv(2);
		wait_idle();
		u_sar_host_model.read_frame(CFG_UNI, w);
		check(32'(w[29:14]), 32'h0000_0F0F);
		check(32'(w[13:0]), 32'h0000_0000);
		check(32'(cfg_word), 32'(CFG_UNI));
	endtask : t_short

	// clock enable low freezes the search in mid conversion
	task automatic t_freeze;
		int n;
		logic [29:0] w;
		@(posedge sys_clk);
		#1 analog_level = 16'hFFFF;
		u_sar_host_model.start_conv(2);
		n = 0;
		while (busy !== 1'b1 && n < 10)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		// three bits decided, bit twelve under trial when frozen
		repeat (5 * CONV_DIV) @(posedge sys_clk);
		#1 clk_en = 1'b0;
		repeat (10) @(posedge sys_clk);
		#1 check(32'({busy, dac_pos_bits}), 32'h0001_F000);
		clk_en = 1'b1;
		wait_idle();
		u_sar_host_model.read_frame(CFG_UNI, w);
		check(32'(w[29:14]), 32'h0000_FFFF);
	endtask : t_freeze

	// main sequence
	initial
	begin
		num_errors = 0;
		compares = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		over_range = 1'b0;
		under_range = 1'b0;
		analog_level = 16'h0000;
		repeat (20) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_walk();
		t_codes();
		t_busy_line();
		t_overlap();
		t_short();
		t_freeze();
		test_done();
	end

	// watchdog sized well above the expected run of about 100 us
	initial
	begin
		#400000;
		num_errors++;
		test_done();
	end
endmodule : tb_sar_conversion_control
`default_nettype wire
